// ===== design/ext_port_pkg.sv
// constants, types and register map of the external memory port sequencer
package ext_port_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int WAIT_W = 4;
  localparam int CNT_W  = 5;

  // clock and wait-state unit: every wait state is one mclk period
  localparam int CLK_MHZ       = 25;
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAIT_CYCLES   = 1;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_STORE_WAITS = 8'h00;
  localparam logic [7:0] OFF_FETCH_WAITS = 8'h04;
  localparam logic [7:0] OFF_TURNAROUND  = 8'h08;
  localparam logic [7:0] OFF_MEM_ADDR    = 8'h0C;
  localparam logic [7:0] OFF_MEM_WDATA   = 8'h10;
  localparam logic [7:0] OFF_COMMAND     = 8'h14;
  localparam logic [7:0] OFF_STATUS      = 8'h18;
  localparam logic [7:0] OFF_READ_DATA   = 8'h1C;

  // field positions inside the wait, turnaround and command registers
  localparam int FLD_SETUP_LSB = 0;
  localparam int FLD_WIDTH_LSB = 4;
  localparam int FLD_HOLD_LSB  = 8;
  localparam int FLD_GAP_LSB   = 0;
  localparam int FLD_ALT_LSB   = 4;
  localparam int FLD_OP_LSB    = 0;

  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_PEND_BIT  = 1;
  localparam int ST_FETCH_BIT = 2;
  localparam int ST_STORE_BIT = 3;

  localparam logic [WAIT_W-1:0] RST_WAITS = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 5'h01;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 5'h00;

  typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE, OP_RMW} op_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WSET, ST_WSTB, ST_WHLD, ST_RSET, ST_RSTB, ST_RHLD, ST_GAP
  } port_state_t;

  typedef struct packed {
    logic [WAIT_W-1:0] hold;
    logic [WAIT_W-1:0] width;
    logic [WAIT_W-1:0] setup;
  } wait_cfg_t;

  typedef struct packed {
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_cmd_t;

endpackage

// ===== design/external_memory_port.sv
// strobe sequencer for asynchronous static memory with an ahb-lite register slave
// What this block does
// - each bus edge relation is a fixed delay plus whole clocks plus wait states.
// - write strobe and data alignment coincide when store width waits are zero.
// - write strobe stays low for the store width wait count, at least one clock.
// - address leads write strobe by one clock plus store setup waits.
// - write data leads write strobe when store width waits are nonzero, lengthened by store setup waits.
// - write data stays stable while the write strobe is low.
// - write data stays driven one clock plus store hold waits after strobe release.
// - address stays unchanged after write strobe rises, for the store hold waits.
// - read strobe falls fetch setup waits after address becomes valid.
// - read strobe rises one clock plus fetch setup and width waits after address.
// - address holds after read strobe release for fetch hold waits.
// - write strobe release and next read strobe are separated by hold and setup.
// - consecutive read strobes are separated by fetch hold plus setup waits.
// - consecutive write strobes are separated by store hold plus setup waits.
// - write after read waits read hold, write setup and turnaround gap controls.
// - address lines stay still between the read and write halves of a read-modify-write and for non-access commands.
// - read data is sampled before the read strobe is released.
// - zero fetch setup and hold keep the read strobe low across back-to-back reads.
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module external_memory_port
  import ext_port_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // memory pins
  output logic [ADDR_W-1:0]      ext_addr,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_n,
  input  wire logic [DATA_W-1:0] data_in,
  output logic                   rd_n,
  output logic                   wr_n
);

  wait_cfg_t          store_waits;
  wait_cfg_t          fetch_waits;
  logic [WAIT_W-1:0]  turnaround_gap_control;
  logic [WAIT_W-1:0]  turnaround_gap_control_alt;
  logic [ADDR_W-1:0]  mem_addr;
  logic [DATA_W-1:0]  mem_wdata;
  logic [DATA_W-1:0]  rd_data;
  logic [DATA_W-1:0]  din_meta;
  logic [DATA_W-1:0]  din_sync;
  logic               dph_valid;
  logic               dph_write;
  logic [7:0]         dph_addr;
  logic               pend_valid;
  mem_cmd_t           pend;
  mem_cmd_t           cur;
  logic               rmw_left;
  logic               last_read;
  port_state_t        state;
  logic [CNT_W-1:0]   cnt;

  // named wait fields
  wire [WAIT_W-1:0] store_setup_wait_states = store_waits.setup;
  wire [WAIT_W-1:0] store_width_wait_states = store_waits.width;
  wire [WAIT_W-1:0] store_hold_wait_states  = store_waits.hold;
  wire [WAIT_W-1:0] fetch_setup_wait_states = fetch_waits.setup;
  wire [WAIT_W-1:0] fetch_width_wait_states = fetch_waits.width;
  wire [WAIT_W-1:0] fetch_hold_wait_states  = fetch_waits.hold;

  // bus decode
  wire       acc        = hsel && htrans[1] && hready;
  wire [7:0] acc_addr   = haddr[7:0];
  wire       bus_wr     = dph_valid && dph_write && hreadyout;
  wire       cmd_wr_now = bus_wr && (dph_addr == OFF_COMMAND);
  wire       cmd_dph    = dph_valid && dph_write && (dph_addr == OFF_COMMAND);
  wire       next_cmd_dph = acc ? (hwrite && acc_addr == OFF_COMMAND) : (cmd_dph && !hreadyout);

  wire        busy      = (state != ST_IDLE) || pend_valid || rmw_left;
  wire [31:0] status_word = 32'(
      {!wr_n, !rd_n, pend_valid, busy} << ST_BUSY_BIT);
  wire [31:0] rd_mux =
      (acc_addr == OFF_STORE_WAITS) ? 32'(store_waits) :
      (acc_addr == OFF_FETCH_WAITS) ? 32'(fetch_waits) :
      (acc_addr == OFF_TURNAROUND)  ? 32'({turnaround_gap_control_alt, turnaround_gap_control}) :
      (acc_addr == OFF_MEM_ADDR)    ? 32'(mem_addr) :
      (acc_addr == OFF_MEM_WDATA)   ? 32'(mem_wdata) :
      (acc_addr == OFF_STATUS)      ? status_word :
      (acc_addr == OFF_READ_DATA)   ? 32'(rd_data) : 32'h0000_0000;

  // next command: the write half of a read-modify-write goes before the queue
  wire             have_cmd  = rmw_left || pend_valid;
  wire             sel_write = rmw_left || (pend.op == OP_WRITE);
  wire [ADDR_W-1:0] sel_addr = rmw_left ? cur.addr : pend.addr;
  wire [DATA_W-1:0] sel_data = rmw_left ? cur.data : pend.data;
  wire [CNT_W-1:0] gap_total = CNT_W'(turnaround_gap_control) + CNT_W'(turnaround_gap_control_alt);
  wire [CNT_W-1:0] w_strobe  = (store_width_wait_states == RST_WAITS) ? CNT_ZERO :
                               CNT_W'(store_width_wait_states) - CNT_ONE;
  wire             stream_rd = (fetch_setup_wait_states == RST_WAITS) &&
                               (fetch_hold_wait_states == RST_WAITS) && !rmw_left &&
                               pend_valid && (pend.op == OP_READ);

  port_state_t      next_state;
  logic [CNT_W-1:0] next_cnt;
  mem_cmd_t         next_cur;
  logic             next_rmw;
  logic             next_last_read;
  logic             take;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_dout;
  logic             next_oe_n;
  logic             next_rd_n;
  logic             next_wr_n;
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_state     = state;
    next_cnt       = cnt - CNT_ONE;
    next_cur       = cur;
    next_rmw       = rmw_left;
    next_last_read = last_read;
    take           = 1'b0;
    next_addr      = ext_addr;
    next_dout      = data_out;
    next_oe_n      = data_oe_n;
    next_rd_n      = rd_n;
    next_wr_n      = wr_n;
    next_rdata     = rd_data;
    unique case (state)
      ST_IDLE: begin
        next_cnt = cnt;
        if (have_cmd && sel_write && last_read && gap_total != CNT_ZERO) begin
          next_state = ST_GAP;
          next_cnt   = gap_total - CNT_ONE;
        end else if (have_cmd) begin
          take     = !rmw_left;
          next_rmw = !rmw_left && (pend.op == OP_RMW);
          if (!rmw_left) begin
            next_cur = pend;
          end
          if (sel_write) begin
            next_addr  = sel_addr;
            next_dout  = sel_data;
            next_oe_n  = (store_width_wait_states == RST_WAITS);
            next_state = ST_WSET;
            next_cnt   = CNT_W'(store_setup_wait_states);
          end else if (pend.op != OP_NONE) begin
            next_addr = pend.addr;
            if (fetch_setup_wait_states == RST_WAITS) begin
              next_rd_n  = 1'b0;
              next_state = ST_RSTB;
              next_cnt   = CNT_W'(fetch_width_wait_states);
            end else begin
              next_state = ST_RSET;
              next_cnt   = CNT_W'(fetch_setup_wait_states) - CNT_ONE;
            end
          end
        end
      end
      ST_WSET: begin
        if (cnt == CNT_ZERO) begin
          next_wr_n  = 1'b0;
          next_oe_n  = 1'b0;
          next_state = ST_WSTB;
          next_cnt   = w_strobe;
        end
      end
      ST_WSTB: begin
        if (cnt == CNT_ZERO) begin
          next_wr_n  = 1'b1;
          next_state = ST_WHLD;
          next_cnt   = CNT_W'(store_hold_wait_states);
        end
      end
      ST_WHLD: begin
        if (cnt == CNT_ZERO) begin
          next_oe_n      = 1'b1;
          next_last_read = 1'b0;
          next_state     = ST_IDLE;
        end
      end
      ST_RSET: begin
        if (cnt == CNT_ZERO) begin
          next_rd_n  = 1'b0;
          next_state = ST_RSTB;
          next_cnt   = CNT_W'(fetch_width_wait_states);
        end
      end
      ST_RSTB: begin
        if (cnt == CNT_ZERO) begin
          next_rdata = din_sync;
          if (stream_rd) begin
            take      = 1'b1;
            next_cur  = pend;
            next_addr = pend.addr;
            next_cnt  = CNT_W'(fetch_width_wait_states);
          end else begin
            next_rd_n      = 1'b1;
            next_last_read = 1'b1;
            next_state     = ST_RHLD;
            next_cnt       = CNT_W'(fetch_hold_wait_states);
          end
        end
      end
      ST_RHLD: begin
        if (cnt == CNT_ZERO) begin
          next_state = ST_IDLE;
        end
      end
      ST_GAP: begin
        if (cnt == CNT_ZERO) begin
          next_last_read = 1'b0;
          next_state     = ST_IDLE;
        end
      end
    endcase
  end

  // a second command write stalls the bus until the queued one is taken
  wire next_pend_valid = cmd_wr_now || (pend_valid && !take);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr  <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      if (hreadyout) begin
        dph_valid <= acc;
        dph_write <= hwrite;
        dph_addr  <= acc_addr;
      end
      hreadyout <= !(next_cmd_dph && next_pend_valid);
      if (acc && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      store_waits                <= '{default: RST_WAITS};
      fetch_waits                <= '{default: RST_WAITS};
      turnaround_gap_control     <= RST_WAITS;
      turnaround_gap_control_alt <= RST_WAITS;
      mem_addr                   <= '0;
      mem_wdata                  <= '0;
      pend_valid                 <= 1'b0;
      pend                       <= '0;
    end else begin
      if (bus_wr && dph_addr == OFF_STORE_WAITS) begin
        store_waits <= wait_cfg_t'(hwdata[FLD_HOLD_LSB+WAIT_W-1:FLD_SETUP_LSB]);
      end
      if (bus_wr && dph_addr == OFF_FETCH_WAITS) begin
        fetch_waits <= wait_cfg_t'(hwdata[FLD_HOLD_LSB+WAIT_W-1:FLD_SETUP_LSB]);
      end
      if (bus_wr && dph_addr == OFF_TURNAROUND) begin
        turnaround_gap_control     <= hwdata[FLD_GAP_LSB +: WAIT_W];
        turnaround_gap_control_alt <= hwdata[FLD_ALT_LSB +: WAIT_W];
      end
      if (bus_wr && dph_addr == OFF_MEM_ADDR) begin
        mem_addr <= hwdata[ADDR_W-1:0];
      end
      if (bus_wr && dph_addr == OFF_MEM_WDATA) begin
        mem_wdata <= hwdata[DATA_W-1:0];
      end
      pend_valid <= next_pend_valid;
      if (cmd_wr_now) begin
        pend <= '{op: op_t'(hwdata[FLD_OP_LSB +: 2]), addr: mem_addr, data: mem_wdata};
      end
    end
  end

  // data pins are asynchronous to mclk; only the second stage is used
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      din_meta <= '0;
      din_sync <= '0;
    end else begin
      din_meta <= data_in;
      din_sync <= din_meta;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      cnt       <= CNT_ZERO;
      cur       <= '0;
      rmw_left  <= 1'b0;
      last_read <= 1'b0;
      ext_addr  <= '0;
      data_out  <= '0;
      data_oe_n <= 1'b1;
      rd_n      <= 1'b1;
      wr_n      <= 1'b1;
      rd_data   <= '0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      cur       <= next_cur;
      rmw_left  <= next_rmw;
      last_read <= next_last_read;
      ext_addr  <= next_addr;
      data_out  <= next_dout;
      data_oe_n <= next_oe_n;
      rd_n      <= next_rd_n;
      wr_n      <= next_wr_n;
      rd_data   <= next_rdata;
    end
  end

  // helper counters for the checks below
  logic [CNT_W:0] wr_low;
  logic [CNT_W:0] rd_low;
  logic           took;
  logic [7:0]     since_rd;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_low   <= '0;
      rd_low   <= '0;
      took     <= 1'b0;
      since_rd <= '1;
    end else begin
      wr_low   <= wr_n ? '0 : wr_low + 1'b1;
      // a launch restarts the count, also when a streamed read keeps the strobe low
      rd_low   <= rd_n ? '0 : (took ? 6'h01 : rd_low + 6'h01);
      took     <= take;
      since_rd <= !rd_n ? '0 : ((&since_rd) ? since_rd : since_rd + 8'h01);
    end
  end
  wire [CNT_W:0] exp_wr = (store_width_wait_states == RST_WAITS) ? 6'h01 :
                          6'(store_width_wait_states);
  // fewest clocks from read release to write strobe, the fraction rounded up to one
  wire [7:0] min_rd_wr = 8'(fetch_hold_wait_states) + 8'(store_setup_wait_states) +
                         8'(gap_total) + 8'h01;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_strobe_excl: assert property (!(rd_n == 1'b0 && wr_n == 1'b0))
    else $error("read and write strobes low together");
  a_wr_width: assert property ($rose(wr_n) |-> wr_low == exp_wr)
    else $error("write strobe width wrong");
  a_wr_setup: assert property ($fell(wr_n) |->
      $past(state) == ST_WSET && $past(cnt) == CNT_ZERO && $stable(ext_addr))
    else $error("write strobe fell outside setup end");
  a_wr_data_lead: assert property (
      $fell(wr_n) && store_width_wait_states != RST_WAITS |-> $past(data_oe_n, 1) == 1'b0)
    else $error("write data not driven ahead of strobe");
  a_wr_data_stable: assert property (!wr_n |-> !data_oe_n ##1 $stable(data_out))
    else $error("write data moved under strobe");
  a_wr_hold: assert property ($rose(wr_n) |->
      (!data_oe_n && $stable(ext_addr)) [*1] ##1 $stable(ext_addr))
    else $error("write data or address not held");
  a_rd_width: assert property (
      $rose(rd_n) |-> rd_low == 6'(fetch_width_wait_states) + 6'h01)
    else $error("read strobe width wrong");
  a_rd_capture: assert property ($rose(rd_n) |-> rd_data == $past(din_sync))
    else $error("read data not sampled at release");
  a_rd_setup: assert property (
      $fell(rd_n) && fetch_setup_wait_states != RST_WAITS |->
      $past(state) == ST_RSET && $stable(ext_addr))
    else $error("read strobe fell early");
  a_addr_quiet: assert property (
      state == ST_IDLE && $past(state) == ST_IDLE && !$past(take) |-> $stable(ext_addr))
    else $error("address moved without access");
  a_rd_stream: assert property (
      state == ST_RSTB && cnt == CNT_ZERO && stream_rd |=> !rd_n)
    else $error("read strobe rose during streamed reads");
  a_turnaround: assert property ($fell(wr_n) |-> since_rd >= min_rd_wr)
    else $error("write after read came too soon");

endmodule

// ===== testbench/static_mem_model.sv
// behavioural asynchronous static memory on the far side of the port
`timescale 1ns/1ps
module static_mem_model
  import ext_port_pkg::*;
(
  // clock and response speed
  input  wire logic              mclk,
  input  wire logic              slow,
  // memory pins
  input  wire logic [ADDR_W-1:0] ext_addr,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  output logic [DATA_W-1:0]      data_in
);
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] last;
  logic              p_wr;
  int                lowc;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {i[7:0], ~i[7:0]};
    end
    last = 16'h0000;
    p_wr = 1'b1;
    lowc = 0;
  end

  // word taken one edge after the strobe rose; data is still held then
  always @(posedge mclk) begin
    if (p_wr === 1'b0 && wr_n === 1'b1) mem[ext_addr[7:0]] <= data_out;
    p_wr <= wr_n;
    lowc <= (rd_n === 1'b0) ? lowc + 1 : 0;
    if (rd_n === 1'b0) last <= mem[ext_addr[7:0]];
  end

  // slow mode answers one clock late; released pins show a changed value
  always_comb begin
    if (data_oe_n === 1'b0) data_in = data_out;
    else if (rd_n === 1'b0 && lowc >= int'(slow)) data_in = mem[ext_addr[7:0]];
    else data_in = ~last;
  end
endmodule

// ===== testbench/tb.sv
// self-checking bench for the external memory port sequencer
`timescale 1ns/1ps
module tb;
  import ext_port_pkg::*;
  logic              mclk;
  logic              rst_n;
  logic              hsel;
  logic [31:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [31:0]       hwdata;
  logic              hready;
  logic              hreadyout;
  logic [31:0]       hrdata;
  logic              hresp;
  logic [ADDR_W-1:0] ext_addr;
  logic [DATA_W-1:0] data_out;
  logic              data_oe_n;
  logic [DATA_W-1:0] data_in;
  logic              rd_n;
  logic              wr_n;
  logic              slow;
  logic              p_wr;
  logic              p_rd;
  logic              p_oe;
  logic [ADDR_W-1:0] p_a;
  logic [31:0]       rv;
  int                bad_count, n_checks, cyc, t_a, t_wf, t_wr, t_oef, t_oer, t_rf, t_rr, n_rf;
  int                g_rw;

  assign hready = hreadyout;

  external_memory_port external_memory_port_i (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_addr(ext_addr),
    .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in), .rd_n(rd_n), .wr_n(wr_n));

  static_mem_model static_mem_model_i (
    .mclk(mclk), .slow(slow), .ext_addr(ext_addr), .data_out(data_out),
    .data_oe_n(data_oe_n), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) cyc <= cyc + 1;

  // pins are settled at the falling edge, so edge times are taken there
  always @(negedge mclk) begin
    if (ext_addr !== p_a) t_a = cyc;
    if (wr_n === 1'b0 && p_wr === 1'b1) begin
      t_wf = cyc;
      g_rw = cyc - t_rr;
    end
    if (wr_n === 1'b1 && p_wr === 1'b0) t_wr = cyc;
    if (rd_n === 1'b1 && p_rd === 1'b0) t_rr = cyc;
    if (data_oe_n === 1'b0 && p_oe === 1'b1) t_oef = cyc;
    if (data_oe_n === 1'b1 && p_oe === 1'b0) t_oer = cyc;
    if (rd_n === 1'b0 && p_rd === 1'b1) begin
      t_rf = cyc;
      n_rf = n_rf + 1;
    end
    p_a = ext_addr;
    p_wr = wr_n;
    p_rd = rd_n;
    p_oe = data_oe_n;
  end

  function automatic logic [15:0] pat(input logic [7:0] a);
    return {a, ~a};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // a hung bus ends the run rather than the simulator's patience
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (hready !== 1'b1 && k < 200);
    if (hready !== 1'b1) begin
      bad_count++;
      summarize();
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      rd(OFF_STATUS);
      k++;
    end while ((rv[ST_BUSY_BIT] !== 1'b0 || rv[ST_PEND_BIT] !== 1'b0) && k < 100);
    if (k >= 100) begin
      bad_count++;
      summarize();
    end
  endtask

  task automatic t_regs();
    for (int i = 0; i < 3; i++) begin
      rd(8'(i * 4));
      chk("wait register reset", rv, 32'h0000_0000);
    end
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40);
    chk("unmapped read", rv, 32'h0000_0000);
    chk("bus response", {31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  task automatic t_write(input int ws, ww, wh, input logic [23:0] a, input logic [15:0] d);
    wr(OFF_STORE_WAITS, 32'(wh * 256 + ww * 16 + ws));
    wr(OFF_MEM_ADDR, {8'h00, a});
    wr(OFF_MEM_WDATA, {16'h0000, d});
    wr(OFF_COMMAND, 32'h0000_0002);
    wait_idle();
    chk("addr to wr fall", t_wf - t_a, ws + 1);
    chk("wr width", t_wr - t_wf, (ww > 0) ? ww : 1);
    chk("data enable fall", t_oef, (ww > 0) ? t_a : t_wf);
    chk("data hold", t_oer - t_wr, wh + 1);
    chk("addr after write", {8'h00, ext_addr}, {8'h00, a});
    chk("stored word", {16'h0000, static_mem_model_i.mem[a[7:0]]}, {16'h0000, d});
  endtask

  task automatic t_read(input int rs, rw, rh, input logic [23:0] a, input logic s,
                        input logic [15:0] e);
    slow <= s;
    wr(OFF_FETCH_WAITS, 32'(rh * 256 + rw * 16 + rs));
    wr(OFF_MEM_ADDR, {8'h00, a});
    wr(OFF_COMMAND, 32'h0000_0001);
    wait_idle();
    chk("addr to rd fall", t_rf - t_a, rs);
    chk("addr to rd rise", t_rr - t_a, rs + rw + 1);
    chk("addr after read", {8'h00, ext_addr}, {8'h00, a});
    rd(OFF_READ_DATA);
    chk("read data", rv, {16'h0000, e});
  endtask

  task automatic t_b2b();
    int n0;
    slow <= 1'b0;
    n0 = n_rf;
    wr(OFF_FETCH_WAITS, 32'h0000_00F0);
    wr(OFF_MEM_ADDR, 32'h0000_0044);
    wr(OFF_COMMAND, 32'h0000_0001);
    wr(OFF_MEM_ADDR, 32'h0000_0055);
    wr(OFF_COMMAND, 32'h0000_0001);
    wait_idle();
    chk("one rd fall", n_rf - n0, 1);
    rd(OFF_READ_DATA);
    chk("second read data", rv, {16'h0000, pat(8'h55)});
  endtask

  // read, then write, then read, the write and second read queued while the port is busy
  task automatic t_turn();
    wr(OFF_TURNAROUND, 32'h0000_0012);
    wr(OFF_FETCH_WAITS, 32'h0000_0150);
    wr(OFF_STORE_WAITS, 32'h0000_0011);
    wr(OFF_MEM_ADDR, 32'h0000_0066);
    wr(OFF_COMMAND, 32'h0000_0001);
    wr(OFF_MEM_ADDR, 32'h0000_0077);
    wr(OFF_MEM_WDATA, 32'h0000_BEEF);
    wr(OFF_COMMAND, 32'h0000_0002);
    wr(OFF_MEM_ADDR, 32'h0000_0088);
    wr(OFF_COMMAND, 32'h0000_0001);
    wait_idle();
    chk("read to write gap", 32'(g_rw >= 6), 32'h0000_0001);
    chk("write to read gap", 32'(t_rf - t_wr >= 1), 32'h0000_0001);
  endtask

  task automatic t_still();
    int ta0;
    ta0 = t_a;
    wr(OFF_MEM_WDATA, 32'h0000_5A5A);
    wr(OFF_COMMAND, 32'h0000_0003);
    wait_idle();
    chk("rmw keeps addr", t_a, ta0);
    chk("rmw stored", {16'h0000, static_mem_model_i.mem[8'h88]}, 32'h0000_5A5A);
    rd(OFF_READ_DATA);
    chk("rmw old data", rv, {16'h0000, pat(8'h88)});
    wr(OFF_MEM_ADDR, 32'h0000_0099);
    wr(OFF_COMMAND, 32'h0000_0000);
    wait_idle();
    chk("none keeps addr", t_a, ta0);
  endtask

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    slow = 1'b0;
    {cyc, bad_count, n_checks, t_a, t_wf, t_wr, t_oef, t_oer, t_rf, t_rr, n_rf, g_rw} = '0;
    {p_wr, p_rd, p_oe} = 3'b111;
    p_a = '0;
    repeat (3) @(posedge mclk);
    chk("strobes in reset", {29'h0, rd_n, wr_n, data_oe_n}, 32'h0000_0007);
    rst_n <= 1'b1;
    t_regs();
    t_write(0, 0, 0, 24'h00_0011, 16'h1234);
    t_write(2, 3, 1, 24'h00_0022, 16'hA5C3);
    t_read(0, 2, 0, 24'h00_0033, 1'b0, pat(8'h33));
    t_read(1, 4, 2, 24'h00_0022, 1'b1, 16'hA5C3);
    t_b2b();
    t_turn();
    t_still();
    summarize();
  end
endmodule
